// >>> src/tksm_defs.vh
// Constants for the two-key setup menu controller.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
`ifndef TKSM_DEFS_VH
`define TKSM_DEFS_VH

// Timing
`define TKSM_CLK_HZ       40000000
`define TKSM_DEB_MS       10
`define TKSM_DEB_CYC      (`TKSM_DEB_MS * (`TKSM_CLK_HZ / 1000))
`define TKSM_TICK_CYC     `TKSM_CLK_HZ

// Register byte offsets
`define TKSM_A_STATUS     8'h00
`define TKSM_A_CONFIG     8'h04
`define TKSM_A_RATED_I    8'h08
`define TKSM_A_SHUNT      8'h0C
`define TKSM_A_RANGES     8'h10
`define TKSM_A_RATED_U    8'h14
`define TKSM_A_DATE       8'h18
`define TKSM_A_TIME       8'h1C
`define TKSM_A_EDIT       8'h20

// Field positions
`define TKSM_ST_SETUP     0
`define TKSM_ST_EDIT      1
`define TKSM_CF_IND_I     0
`define TKSM_CF_HALL      1
`define TKSM_CF_IND_U     2

// Reset values
`define TKSM_RST_RATED_I  20'h00020
`define TKSM_RST_SHUNT    12'h100
`define TKSM_RST_RATED_U  16'h0000
`define TKSM_RST_LAMP     3'h5
`define TKSM_RST_PWD      16'h0000
`define TKSM_RST_DATE     24'h000101
`define TKSM_RST_TIME     24'h000000
`define TKSM_RST_CONFIG   3'h1

// Value limits (BCD)
`define TKSM_I_MIN        20'h00020
`define TKSM_I_MAX        20'h50000
`define TKSM_SH_MIN       12'h050
`define TKSM_SH_MAX       12'h100
`define TKSM_U_MAX        16'h3000
`define TKSM_HOUR_MAX     8'h23
`define TKSM_MINSEC_MAX   8'h59
`define TKSM_LAMP_MIN     3'h1
`define TKSM_LAMP_MAX     3'h5

`endif

// >>> src/tksm_menu.v
// Two-key front-panel setup menu with APB register access.
// Keys are active-low pins from outside; APB runs on clk_i.
//
// How it works
// - Chord in metering enters setup mode
// - Chord in setup returns to metering
// - Outside edit: increment changes, advance steps
// - Edit: increment raises flashing digit
// - Edit: advance moves cursor to next digit
// - Advance on last digit commits, leaves edit
// - Password screen first, default code 0000
// - Rated current accepted only 20..50000
// - Rated current screen only if indirect
// - Shunt span accepted only 50..100 mV
// - Current range code 0 default, 0/1
// - Fixed screen order, advance steps
// - Voltage range code 0 default, 0/1
// - Energy clear: Yes after two presses
// - Charge clear: Yes after two presses
// - Counter clear: Yes after two presses
// - Lamp level one to five
// - Advance after date goes to time
// - Time and clock in 24-hour format
`include "tksm_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module tksm_menu #(
  parameter integer DEB_CYC  = `TKSM_DEB_CYC,
  parameter integer TICK_CYC = `TKSM_TICK_CYC
) (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire        key_inc_n_i,
  input  wire        key_adv_n_i,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         setup_active_o,
  output reg         edit_active_o,
  output reg  [3:0]  screen_o,
  output reg  [2:0]  cursor_o,
  output reg  [2:0]  lamp_level_o,
  output reg         energy_clr_o,
  output reg         charge_clr_o,
  output reg         pulse_input_clr_o
);

  localparam [3:0] SC_METER   = 4'h0;
  localparam [3:0] SC_PASS    = 4'h1;
  localparam [3:0] SC_RATED_I = 4'h2;
  localparam [3:0] SC_SHUNT   = 4'h3;
  localparam [3:0] SC_I_RNG   = 4'h4;
  localparam [3:0] SC_RATED_U = 4'h5;
  localparam [3:0] SC_U_RNG   = 4'h6;
  localparam [3:0] SC_EN_CLR  = 4'h7;
  localparam [3:0] SC_CH_CLR  = 4'h8;
  localparam [3:0] SC_CT_CLR  = 4'h9;
  localparam [3:0] SC_LAMP    = 4'hA;
  localparam [3:0] SC_DATE    = 4'hB;
  localparam [3:0] SC_TIME    = 4'hC;
  localparam [3:0] SC_PWD     = 4'hD;

  // Key conditioning, one lane per key
  wire [1:0] key_pin_n = {key_adv_n_i, key_inc_n_i};
  wire [1:0] key_held;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_key
      reg        s1_q;
      reg        s2_q;
      reg        st_q;
      reg [31:0] cnt_q;
      always @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          s1_q  <= 1'b1;
          s2_q  <= 1'b1;
          st_q  <= 1'b1;
          cnt_q <= 32'h0;
        end
        else
        begin
          s1_q <= key_pin_n[g];
          s2_q <= s1_q;
          if (s2_q == st_q)
            cnt_q <= 32'h0;
          else if (cnt_q >= DEB_CYC - 1)
          begin
            st_q  <= s2_q;
            cnt_q <= 32'h0;
          end
          else
            cnt_q <= cnt_q + 32'h1;
        end
      end
      assign key_held[g] = ~st_q;
    end
  endgenerate

  // Press events decoded when all keys are released
  reg  [1:0] seen_q;
  reg        any_q;
  wire       rel = any_q & ~(|key_held);
  wire       ev_combo = rel & seen_q[0] & seen_q[1];
  wire       ev_inc   = rel & seen_q[0] & ~seen_q[1];
  wire       ev_adv   = rel & seen_q[1] & ~seen_q[0];

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      seen_q <= 2'b00;
      any_q  <= 1'b0;
    end
    else
    begin
      any_q  <= |key_held;
      seen_q <= rel ? 2'b00 : (seen_q | key_held);
    end
  end

  // Menu state and settings
  reg [3:0]  scr_q;
  reg        edit_q;
  reg [2:0]  cur_q;
  reg [23:0] buf_q;
  reg [1:0]  yes_cnt_q;
  reg [19:0] rated_i_q;
  reg [11:0] shunt_q;
  reg [15:0] rated_u_q;
  reg        irng_q;
  reg        urng_q;
  reg [2:0]  lamp_q;
  reg [23:0] date_q;
  reg [23:0] time_q;
  reg [15:0] pwd_q;
  reg [2:0]  cfg_q;
  reg [31:0] tick_q;

  // Flashing digit increment, nibble by nibble
  wire [23:0] inc_buf;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_dig
      wire [3:0] nib = buf_q[4*g+3:4*g];
      assign inc_buf[4*g+3:4*g] = (cur_q != g) ? nib :
                                  (nib == 4'h9) ? 4'h0 : nib + 4'h1;
    end
  endgenerate

  // Screens present for this build
  wire [15:0] pres;
  // rated current only for indirect build
  assign pres = {2'b11, 7'h7F,
                 cfg_q[`TKSM_CF_IND_U], cfg_q[`TKSM_CF_IND_U],
                 cfg_q[`TKSM_CF_HALL],
                 cfg_q[`TKSM_CF_IND_I] & ~cfg_q[`TKSM_CF_HALL],
                 cfg_q[`TKSM_CF_IND_I], 2'b00};

  function [3:0] nxt_scr;
    input [3:0]  s;
    input [15:0] p;
    integer k;
    reg     hit;
    begin
      nxt_scr = SC_PWD;
      hit     = 1'b0;
      for (k = 13; k >= 2; k = k - 1)
        if (p[k] && k > s)
        begin
          nxt_scr = k[3:0];
          hit     = 1'b1;
        end
      if (!hit)
        for (k = 13; k >= 2; k = k - 1)
          if (p[k])
            nxt_scr = k[3:0];
    end
  endfunction

  function [2:0] ndig;
    input [3:0] s;
    begin
      case (s)
        SC_RATED_I: ndig = 3'd5;
        SC_SHUNT:   ndig = 3'd3;
        SC_DATE:    ndig = 3'd6;
        SC_TIME:    ndig = 3'd6;
        default:    ndig = 3'd4;
      endcase
    end
  endfunction

  function [23:0] time_inc;
    input [23:0] t;
    begin
      time_inc = t;
      if (t[3:0] != 4'h9)
        time_inc[3:0] = t[3:0] + 4'h1;
      else if (t[7:4] != 4'h5)
        time_inc[7:0] = {t[7:4] + 4'h1, 4'h0};
      else if (t[11:8] != 4'h9)
        time_inc[15:0] = {t[15:12], t[11:8] + 4'h1, 8'h00};
      else if (t[15:12] != 4'h5)
        time_inc[15:0] = {t[15:12] + 4'h1, 12'h000};
      else if (t[23:16] == `TKSM_HOUR_MAX)
        time_inc = 24'h000000;
      else if (t[19:16] == 4'h9)
        time_inc = {t[23:20] + 4'h1, 20'h00000};
      else
        time_inc = {t[23:20], t[19:16] + 4'h1, 16'h0000};
    end
  endfunction

  wire is_edit_scr = (scr_q == SC_PASS) || (scr_q == SC_RATED_I) ||
                     (scr_q == SC_SHUNT) || (scr_q == SC_RATED_U) ||
                     (scr_q == SC_DATE) || (scr_q == SC_TIME) ||
                     (scr_q == SC_PWD);
  wire date_ok = (buf_q[15:8] != 8'h00) && (buf_q[15:8] <= 8'h12) &&
                 (buf_q[7:0] != 8'h00) && (buf_q[7:0] <= 8'h31);
  wire time_ok = (buf_q[23:16] <= `TKSM_HOUR_MAX) &&
                 (buf_q[15:8] <= `TKSM_MINSEC_MAX) &&
                 (buf_q[7:0] <= `TKSM_MINSEC_MAX);
  wire       tick = (tick_q >= TICK_CYC - 1);
  wire [3:0] scr_next = nxt_scr(scr_q, pres);
  wire       apb_wr = psel & penable & pwrite & ~pready;

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      scr_q     <= SC_METER;
      edit_q    <= 1'b0;
      cur_q     <= 3'h0;
      buf_q     <= 24'h0;
      yes_cnt_q <= 2'h0;
      rated_i_q <= `TKSM_RST_RATED_I;
      shunt_q   <= `TKSM_RST_SHUNT;
      rated_u_q <= `TKSM_RST_RATED_U;
      irng_q    <= 1'b0;
      urng_q    <= 1'b0;
      lamp_q    <= `TKSM_RST_LAMP;
      date_q    <= `TKSM_RST_DATE;
      time_q    <= `TKSM_RST_TIME;
      pwd_q     <= `TKSM_RST_PWD;
      cfg_q     <= `TKSM_RST_CONFIG;
      tick_q    <= 32'h0;
      energy_clr_o      <= 1'b0;
      charge_clr_o      <= 1'b0;
      pulse_input_clr_o <= 1'b0;
    end
    else
    begin
      energy_clr_o      <= 1'b0;
      charge_clr_o      <= 1'b0;
      pulse_input_clr_o <= 1'b0;
      tick_q <= tick ? 32'h0 : tick_q + 32'h1;
      if (tick)
        time_q <= time_inc(time_q);
      if (apb_wr && paddr == `TKSM_A_CONFIG)
        cfg_q <= pwdata[2:0];
      if (ev_combo)
      begin
        edit_q <= 1'b0;
        if (scr_q == SC_METER)
        begin
          scr_q <= SC_PASS;
          buf_q <= 24'h0;
        end
        else
          scr_q <= SC_METER;
      end
      else if (scr_q != SC_METER && edit_q)
      begin
        if (ev_inc)
          buf_q <= inc_buf;
        else if (ev_adv && cur_q != 3'h0)
        begin
          cur_q <= cur_q - 3'h1;
        end
        else if (ev_adv)
        begin
          edit_q <= 1'b0;
          case (scr_q)
            SC_RATED_I:
              if (buf_q[19:0] >= `TKSM_I_MIN &&
                  buf_q[19:0] <= `TKSM_I_MAX)
                rated_i_q <= buf_q[19:0];
            SC_SHUNT:
              if (buf_q[11:0] >= `TKSM_SH_MIN &&
                  buf_q[11:0] <= `TKSM_SH_MAX)
                shunt_q <= buf_q[11:0];
            SC_RATED_U:
              if (buf_q[15:0] <= `TKSM_U_MAX)
                rated_u_q <= buf_q[15:0];
            SC_DATE:
              if (date_ok)
                date_q <= buf_q;
            SC_TIME:
              if (time_ok)
                time_q <= buf_q;
            SC_PWD:
              pwd_q <= buf_q[15:0];
            default:
              buf_q <= buf_q;
          endcase
        end
      end
      else if (scr_q != SC_METER)
      begin
        if (ev_inc)
        begin
          case (scr_q)
            SC_I_RNG:
              irng_q <= ~irng_q;
            SC_U_RNG:
              urng_q <= ~urng_q;
            SC_LAMP:
              lamp_q <= (lamp_q >= `TKSM_LAMP_MAX) ? `TKSM_LAMP_MIN :
                        lamp_q + 3'h1;
            SC_EN_CLR, SC_CH_CLR, SC_CT_CLR:
              yes_cnt_q <= (yes_cnt_q == 2'h2) ? 2'h0 : yes_cnt_q + 2'h1;
            default:
              if (is_edit_scr)
              begin
                edit_q <= 1'b1;
                cur_q  <= ndig(scr_q) - 3'h1;
                if (scr_q != SC_PASS)
                  buf_q <= 24'h0;
                case (scr_q)
                  SC_RATED_I: buf_q <= {4'h0, rated_i_q};
                  SC_SHUNT:   buf_q <= {12'h000, shunt_q};
                  SC_RATED_U: buf_q <= {8'h00, rated_u_q};
                  SC_DATE:    buf_q <= date_q;
                  SC_TIME:    buf_q <= time_q;
                  SC_PWD:     buf_q <= {8'h00, pwd_q};
                  default:    buf_q <= buf_q;
                endcase
              end
          endcase
        end
        else if (ev_adv)
        begin
          yes_cnt_q <= 2'h0;
          energy_clr_o <= (scr_q == SC_EN_CLR) && (yes_cnt_q == 2'h2);
          charge_clr_o <= (scr_q == SC_CH_CLR) && (yes_cnt_q == 2'h2);
          pulse_input_clr_o <= (scr_q == SC_CT_CLR) &&
                               (yes_cnt_q == 2'h2);
          if (scr_q == SC_PASS && buf_q[15:0] != pwd_q)
            scr_q <= SC_METER;
          else
            scr_q <= scr_next;
        end
      end
    end
  end

  // Register outputs and APB slave
  reg [31:0] rd_mux;
  reg        rd_err;
  always @*
  begin
    rd_err = 1'b0;
    case (paddr)
      `TKSM_A_STATUS:  rd_mux = {16'h0, 2'h0, yes_cnt_q, scr_q,
                                 1'b0, cur_q, 2'h0, edit_q,
                                 scr_q != SC_METER};
      `TKSM_A_CONFIG:  rd_mux = {29'h0, cfg_q};
      `TKSM_A_RATED_I: rd_mux = {12'h0, rated_i_q};
      `TKSM_A_SHUNT:   rd_mux = {20'h0, shunt_q};
      `TKSM_A_RANGES:  rd_mux = {25'h0, lamp_q, 2'h0, urng_q, irng_q};
      `TKSM_A_RATED_U: rd_mux = {16'h0, rated_u_q};
      `TKSM_A_DATE:    rd_mux = {8'h0, date_q};
      `TKSM_A_TIME:    rd_mux = {8'h0, time_q};
      `TKSM_A_EDIT:    rd_mux = {8'h0, buf_q};
      default:
      begin
        rd_mux = 32'h0;
        rd_err = 1'b1;
      end
    endcase
  end

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      prdata         <= 32'h0;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      setup_active_o <= 1'b0;
      edit_active_o  <= 1'b0;
      screen_o       <= 4'h0;
      cursor_o       <= 3'h0;
      lamp_level_o   <= `TKSM_RST_LAMP;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rd_err;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rd_mux;
      setup_active_o <= (scr_q != SC_METER);
      edit_active_o  <= edit_q;
      screen_o       <= scr_q;
      cursor_o       <= cur_q;
      lamp_level_o   <= lamp_q;
    end
  end

endmodule // tksm_menu

`default_nettype wire

// >>> test/tksm_keys.sv
// Operator model: two front-panel push keys.
// Assumes a free-running clk_i; key pins are active low.
`timescale 1ns/1ps
`default_nettype none
module tksm_keys #(
  parameter integer DEB_CYC = 4
) (
  input  wire logic clk_i,
  output var  logic inc_n_o,
  output var  logic adv_n_o
);
  initial
  begin
    inc_n_o = 1'b1;
    adv_n_o = 1'b1;
  end

  task automatic press(input logic inc, input logic adv);
    begin
      @(posedge clk_i);
      inc_n_o <= ~inc;
      @(posedge clk_i);
      adv_n_o <= ~adv;
      repeat (DEB_CYC + 8) @(posedge clk_i);
      inc_n_o <= 1'b1;
      adv_n_o <= 1'b1;
      repeat (DEB_CYC + 12) @(posedge clk_i);
    end
  endtask

  task automatic glitch();
    begin
      @(posedge clk_i);
      inc_n_o <= 1'b0;
      repeat (DEB_CYC - 2) @(posedge clk_i);
      inc_n_o <= 1'b1;
      repeat (DEB_CYC + 12) @(posedge clk_i);
    end
  endtask
endmodule // tksm_keys
`default_nettype wire

// >>> test/tksm_menu_asserts.sv
// Assertion checker for the setup menu outputs.
// Sees only the menu's ports; bound into every tksm_menu.
`timescale 1ns/1ps
`default_nettype none
module tksm_menu_asserts (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       setup_active_o,
  input wire logic       edit_active_o,
  input wire logic [3:0] screen_o,
  input wire logic [2:0] cursor_o,
  input wire logic [2:0] lamp_level_o,
  input wire logic       energy_clr_o,
  input wire logic       charge_clr_o,
  input wire logic       pulse_input_clr_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_setup_flag;
    setup_active_o == (screen_o != 4'h0);
  endproperty
  a_setup_flag: assert property (p_setup_flag)
    else $error("setup flag disagrees with screen");
  property p_enter_pwd;
    $rose(setup_active_o) |-> screen_o == 4'h1;
  endproperty
  a_enter_pwd: assert property (p_enter_pwd)
    else $error("setup not entered at password screen");
  property p_edit_entry;
    $rose(edit_active_o) && screen_o == 4'h1 |-> cursor_o == 3'h3;
  endproperty
  a_edit_entry: assert property (p_edit_entry)
    else $error("password edit not started at first digit");
  property p_cursor_step;
    edit_active_o && $past(edit_active_o) && $changed(cursor_o)
      |-> cursor_o == $past(cursor_o) - 3'h1;
  endproperty
  a_cursor_step: assert property (p_cursor_step)
    else $error("cursor did not step to next digit");
  property p_edit_exit;
    $fell(edit_active_o) && setup_active_o |-> $past(cursor_o) == 3'h0;
  endproperty
  a_edit_exit: assert property (p_edit_exit)
    else $error("edit left before last digit");
  property p_energy;
    energy_clr_o |-> ($past(screen_o) == 4'h7 || screen_o == 4'h7)
      ##1 !energy_clr_o;
  endproperty
  a_energy: assert property (p_energy)
    else $error("energy clear outside its screen or too long");
  property p_charge;
    charge_clr_o |-> ($past(screen_o) == 4'h8 || screen_o == 4'h8)
      ##1 !charge_clr_o;
  endproperty
  a_charge: assert property (p_charge)
    else $error("charge clear outside its screen or too long");
  property p_counter;
    pulse_input_clr_o |-> ($past(screen_o) == 4'h9 || screen_o == 4'h9)
      ##1 !pulse_input_clr_o;
  endproperty
  a_counter: assert property (p_counter)
    else $error("counter clear outside its screen or too long");
  property p_lamp;
    lamp_level_o >= 3'h1 && lamp_level_o <= 3'h5;
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("lamp level out of range");
endmodule // tksm_menu_asserts

bind tksm_menu tksm_menu_asserts u_asserts (
  .clk_i             (clk_i),
  .sys_rst_i         (sys_rst_i),
  .setup_active_o    (setup_active_o),
  .edit_active_o     (edit_active_o),
  .screen_o          (screen_o),
  .cursor_o          (cursor_o),
  .lamp_level_o      (lamp_level_o),
  .energy_clr_o      (energy_clr_o),
  .charge_clr_o      (charge_clr_o),
  .pulse_input_clr_o (pulse_input_clr_o)
);
`default_nettype wire

// >>> test/two_key_setup_menu_test.sv
// Self-checking bench for the two-key setup menu.
// Keys come from the operator model; state is read over APB.
`timescale 1ns/1ps
`default_nettype none
module two_key_setup_menu_test;
  localparam integer DEB = 4;
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h00000000;
  logic [31:0] q;
  logic        perr;
  wire  logic [31:0] prdata;
  wire  logic        pready, pslverr, inc_n, adv_n;
  wire  logic        setup_active_o, edit_active_o;
  wire  logic [3:0]  screen_o;
  wire  logic [2:0]  cursor_o, lamp_level_o, clr;
  int          err_total = 0;
  int          n_tests   = 0;
  int          n_clr [3] = '{0, 0, 0};

  always #12.5 clk_i = ~clk_i;

  tksm_keys #(.DEB_CYC(DEB)) u_keys (
    .clk_i   (clk_i),
    .inc_n_o (inc_n),
    .adv_n_o (adv_n)
  );

  tksm_menu #(.DEB_CYC(DEB), .TICK_CYC(100000)) dut (
    .clk_i             (clk_i),
    .sys_rst_i         (sys_rst_i),
    .key_inc_n_i       (inc_n),
    .key_adv_n_i       (adv_n),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .setup_active_o    (setup_active_o),
    .edit_active_o     (edit_active_o),
    .screen_o          (screen_o),
    .cursor_o          (cursor_o),
    .lamp_level_o      (lamp_level_o),
    .energy_clr_o      (clr[0]),
    .charge_clr_o      (clr[1]),
    .pulse_input_clr_o (clr[2])
  );

  always @(posedge clk_i)
    for (int k = 0; k < 3; k++)
      if (clr[k] === 1'b1)
        n_clr[k] <= n_clr[k] + 1;

  task automatic test_done();
    begin
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_tests++;
      if (got !== exp)
      begin
        err_total++;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    begin
      @(posedge clk_i);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1)
        @(posedge clk_i);
      q = prdata;
      perr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    begin
      apb(1'b0, a, 32'h00000000);
      check(q, exp);
    end
  endtask

  task automatic key(input logic i, input logic a, input int n);
    repeat (n) u_keys.press(i, a);
  endtask

  task automatic ui(input logic [3:0] s, input logic e,
                    input logic [2:0] c);
    begin
      check({setup_active_o, edit_active_o, screen_o}, {s != 4'h0, e, s});
      if (e)
        check(cursor_o, c);
    end
  endtask

  initial
  begin
    repeat (10000) @(posedge clk_i);
    err_total++;
    test_done();
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (DEB + 4) @(posedge clk_i);
    check(lamp_level_o, 3'h5);
    rd(8'h04, 32'h00000001);
    rd(8'h08, 32'h00000020);
    rd(8'h0C, 32'h00000100);
    rd(8'h10, 32'h00000050);
    apb(1'b1, 8'h08, 32'h00000001);
    rd(8'h08, 32'h00000020);
    rd(8'h24, 32'h00000000);
    check(perr, 1'b1);
    key(1, 0, 1); ui(4'h0, 0, 0);
    key(1, 1, 1); ui(4'h1, 0, 0);
    key(1, 1, 1); ui(4'h0, 0, 0);
    key(1, 1, 1); key(1, 0, 1); ui(4'h1, 1, 3);
    u_keys.glitch(); rd(8'h20, 32'h00000000);
    key(1, 0, 1); rd(8'h20, 32'h00001000);
    key(0, 1, 1); ui(4'h1, 1, 2);
    key(0, 1, 3); ui(4'h1, 0, 0);
    key(0, 1, 1); ui(4'h0, 0, 0);
    key(1, 1, 1); key(0, 1, 1); ui(4'h2, 0, 0);
    key(1, 0, 7); key(0, 1, 5); rd(8'h08, 32'h00000020);
    key(1, 0, 2); key(0, 1, 5); rd(8'h08, 32'h00010020);
    key(0, 1, 1); ui(4'h3, 0, 0);
    key(1, 0, 2); key(0, 1, 3); rd(8'h0C, 32'h00000100);
    key(0, 1, 1); ui(4'h7, 0, 0);
    key(1, 0, 2); key(0, 1, 1); check(n_clr[0], 1);
    key(1, 0, 2); key(0, 1, 1); check(n_clr[1], 1);
    key(1, 0, 3); key(0, 1, 1); check(n_clr[2], 0);
    key(1, 0, 2); key(0, 1, 1); check(lamp_level_o, 3'h2);
    key(1, 0, 1); key(0, 1, 6); ui(4'hB, 0, 0);
    key(0, 1, 1); ui(4'hC, 0, 0);
    key(1, 0, 3); key(0, 1, 1); key(1, 0, 3); key(0, 1, 5);
    rd(8'h1C, 32'h00230000);
    key(0, 1, 1); ui(4'hD, 0, 0);
    key(1, 0, 2); key(0, 1, 4); ui(4'hD, 0, 0);
    key(1, 1, 1); ui(4'h0, 0, 0);
    apb(1'b1, 8'h04, 32'h00000007);
    rd(8'h04, 32'h00000007);
    key(1, 1, 1); key(0, 1, 1); ui(4'h0, 0, 0);
    key(1, 1, 1); key(1, 0, 2); key(0, 1, 6); ui(4'h4, 0, 0);
    key(1, 0, 1); key(0, 1, 1); ui(4'h5, 0, 0);
    rd(8'h10, 32'h00000021);
    key(0, 1, 1); ui(4'h6, 0, 0);
    key(1, 0, 1); key(0, 1, 1); rd(8'h10, 32'h00000023);
    test_done();
  end
endmodule // two_key_setup_menu_test
`default_nettype wire
